// file: logic/brld_consts.vh
`ifndef BRLD_CONSTS_VH
`define BRLD_CONSTS_VH

// Register map of the AHB-Lite slave (byte addresses).
`define BRLD_OFS_INSTR      8'h00
`define BRLD_OFS_OPND       8'h04
`define BRLD_OFS_GO         8'h08
`define BRLD_OFS_STATUS     8'h0C
`define BRLD_OFS_FLAGS      8'h10
`define BRLD_OFS_PC         8'h14
`define BRLD_OFS_REG_BASE   8'h40
`define BRLD_OFS_MEM_BASE   8'h80

// Status-flag bit positions.
`define BRLD_FLAG_C 3'd0
`define BRLD_FLAG_Z 3'd1
`define BRLD_FLAG_N 3'd2
`define BRLD_FLAG_V 3'd3
`define BRLD_FLAG_S 3'd4
`define BRLD_FLAG_H 3'd5
`define BRLD_FLAG_T 3'd6
`define BRLD_FLAG_I 3'd7

// Pointer pair base registers.
`define BRLD_PTR_X 5'd26
`define BRLD_PTR_Y 5'd28
`define BRLD_PTR_Z 5'd30

// Reset values.
`define BRLD_RST_PC    16'h0000
`define BRLD_RST_FLAGS 8'h00

// Cycle counts.
`define BRLD_CYC_ONE 2'd1
`define BRLD_CYC_TWO 2'd2

`endif

// file: logic/brld_core.v
// Behaviour
// [RULE_01] Flag-bit-one branch: selected status bit one gives PC+offset+1. Index 4 tests N xor V instead of the stored S bit.
// [RULE_02] Flag-bit-zero branch: selected status bit zero gives PC+offset+1. Index 4 tests N xor V instead of the stored S bit.
// [RULE_03] Equal branch when zero flag one; flags are never changed.
// [RULE_04] Unequal branch when zero flag zero.
// [RULE_05] Carry branches test carry, one form per level.
// [RULE_06] Unsigned ge equals carry-zero; unsigned lt equals carry-one.
// [RULE_07] Negative branch on N one, positive branch on N zero.
// [RULE_08] Signed ge branch when N xor V is zero.
// [RULE_09] Signed lt branch when N xor V is one.
// [RULE_10] Half-carry branches test H, one form per level.
// [RULE_11] User-bit branches test T, one form per level.
// [RULE_12] Overflow branches test V, one form per level.
// [RULE_13] Interrupt-state branches test I, one form per level.
// [RULE_14] Register copy, pair copy, constant load: one cycle, flags unchanged.
// [RULE_15] Pointer load reads pointed byte, optional post-increment, two cycles.
// [RULE_16] Pre-decrement load decrements pointer then reads, two cycles.
// [RULE_17] Offset load reads Y or Z plus displacement, pointer kept, two cycles.
// [RULE_18] Absolute load reads the given address, two cycles, no flags.
// [RULE_19] X store writes source, optional post-increment, two cycles.
// [RULE_20] Branch takes one cycle if not taken, two if taken.
// [RULE_21] Branch offset is a signed two's-complement word offset.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "brld_consts.vh"

module brld_core (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_b_i,
    // AHB-Lite slave
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output reg [31:0] hrdata_o,
    output reg hreadyout_o,
    output reg hresp_o,
    // Execution status
    output reg busy_o,
    output reg done_o,
    output reg [15:0] pc_o
);

    // Operation codes written to the instruction register.
    localparam [4:0] OP_BR_SET = 5'd0;
    localparam [4:0] OP_BR_CLR = 5'd1;
    localparam [4:0] OP_COPY = 5'd2;
    localparam [4:0] OP_COPY_PAIR = 5'd3;
    localparam [4:0] OP_LOAD_K = 5'd4;
    localparam [4:0] OP_LD_PTR = 5'd5;
    localparam [4:0] OP_LD_INC = 5'd6;
    localparam [4:0] OP_LD_DEC = 5'd7;
    localparam [4:0] OP_LD_OFS = 5'd8;
    localparam [4:0] OP_LD_ABS = 5'd9;
    localparam [4:0] OP_ST_X = 5'd10;
    localparam [4:0] OP_ST_X_INC = 5'd11;

    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_EXEC = 2'd1;
    localparam [1:0] ST_LAST = 2'd2;

    ////////////////////////////////////////////////////////////////////////////////
    // Storage

    // Both arrays live here rather than in a shared memory, so that a load can
    // update its pointer pair and move its byte in the same edge.
    reg [7:0] gpr_q [0:31];
    reg [7:0] mem_q [0:63];
    reg [7:0] flags_q;
    reg [31:0] instr_q;
    reg [31:0] opnd_q;
    reg [1:0] state_q;
    reg [1:0] cycles_q;

    // Instruction word: [4:0] op, [9:5] rd, [14:10] rr, [17:15] flag index,
    // [19:18] pointer select (0 X, 1 Y, 2 Z). Operand word: [15:0] offset,
    // displacement, constant or absolute address.
    wire [4:0] op = instr_q[4:0];
    wire [4:0] rd = instr_q[9:5];
    wire [4:0] rr = instr_q[14:10];
    wire [2:0] fsel = instr_q[17:15];
    wire [1:0] psel = instr_q[19:18];
    wire [15:0] kval = opnd_q[15:0];

    // Per-operation strobes used by the execution and branch logic.
    wire is_br_set = (op == OP_BR_SET);
    wire is_branch = (op == OP_BR_SET) | (op == OP_BR_CLR);
    wire is_ld_inc = (op == OP_LD_INC);
    wire is_ld_dec = (op == OP_LD_DEC);
    wire is_st_x_inc = (op == OP_ST_X_INC);

    // Pointer pair select; code 3 falls back to X.
    reg [4:0] pbase;
    always @* begin
        case (psel)
            2'd1: pbase = `BRLD_PTR_Y;
            2'd2: pbase = `BRLD_PTR_Z;
            default: pbase = `BRLD_PTR_X;
        endcase
    end

    // Pointer arithmetic wraps at 16 bits; only the low six address bits
    // reach the data memory, so the memory repeats through the pointer range.
    wire [4:0] pbase_hi = pbase + 5'd1;
    wire [15:0] ptr = {gpr_q[pbase_hi], gpr_q[pbase]};
    wire [15:0] ptr_dec = ptr - 16'h0001;
    wire [15:0] ptr_inc = ptr + 16'h0001;
    wire [15:0] xptr = {gpr_q[`BRLD_PTR_X + 5'd1], gpr_q[`BRLD_PTR_X]};
    wire [15:0] xptr_inc = xptr + 16'h0001;

    ////////////////////////////////////////////////////////////////////////////////
    // Branch decision

    // Named forms map to a flag index and a polarity, so unsigned ge/lt are
    // literally the carry-zero/carry-one branches. Software encodes them so:
    //   equal, unequal: index 1; carry one, carry zero: index 0;
    //   unsigned lt, unsigned ge: index 0; negative, positive: index 2;
    //   overflow one, overflow zero: index 3; signed lt, signed ge: index 4;
    //   half-carry one, zero: index 5; user bit one, zero: index 6;
    //   interrupts on, off: index 7. The first of each pair is the set form.
    wire nxv = flags_q[`BRLD_FLAG_N] ^ flags_q[`BRLD_FLAG_V];

    // Condition per flag index. Index 4 is evaluated as N xor V rather than
    // read from the stored sign bit, so the signed forms follow N and V even
    // when software has left that bit stale.
    wire [7:0] cond_vec;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_cond
            if (g == `BRLD_FLAG_S) begin : g_signed
                assign cond_vec[g] = nxv; // [RULE_08] [RULE_09]
            end else begin : g_plain // [RULE_11] [RULE_12] [RULE_13]
                assign cond_vec[g] = flags_q[g]; // [RULE_05] [RULE_06] [RULE_07] [RULE_10]
            end
        end
    endgenerate

    wire test_bit = cond_vec[fsel];
    // Flags are only ever written from the bus, never by execution.
    wire br_taken = is_br_set ? test_bit : ~test_bit; // [RULE_01] [RULE_02] [RULE_03] [RULE_04]
    wire [15:0] br_target = pc_o + kval + 16'h0001; // [RULE_21]

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave

    // Zero wait states: hreadyout never drops. Read data is registered at the
    // address-phase edge, so it stands through the whole data phase; write
    // data is taken at the edge that ends the data phase.
    reg ap_valid_q;
    reg ap_write_q;
    reg [7:0] ap_addr_q;
    wire ap_take = hsel_i & hready_i & htrans_i[1];
    wire go_wr = ap_valid_q & ap_write_q & (ap_addr_q == `BRLD_OFS_GO) & ~busy_o;

    // Address regions. General registers 0..15 sit at 0x40 + 4n; the upper
    // half of the file is reached only through instructions, since its
    // window would collide with data memory.
    wire [7:0] raddr = haddr_i[7:0];
    wire raddr_gpr_hit = (raddr[7:6] == 2'b01);
    wire raddr_mem_hit = raddr[7];
    wire [4:0] raddr_gpr_idx = {1'b0, raddr[5:2]};
    wire [5:0] raddr_mem_idx = {raddr[6], raddr[6:2]};

    // Unmapped addresses read as zero. STATUS also shows how many cycles the
    // last instruction took.
    reg [31:0] rdata;
    always @* begin
        rdata = 32'h0000_0000;
        if (raddr_gpr_hit) begin
            rdata = {24'h00_0000, gpr_q[raddr_gpr_idx]};
        end else if (raddr_mem_hit) begin
            rdata = {24'h00_0000, mem_q[raddr_mem_idx]};
        end else begin
            case (raddr)
                `BRLD_OFS_INSTR: rdata = instr_q;
                `BRLD_OFS_OPND: rdata = opnd_q;
                `BRLD_OFS_STATUS: rdata = {28'h000_0000, cycles_q, done_o, busy_o};
                `BRLD_OFS_FLAGS: rdata = {24'h00_0000, flags_q};
                `BRLD_OFS_PC: rdata = {16'h0000, pc_o};
                default: rdata = 32'h0000_0000;
            endcase
        end
    end

    // Address-phase capture for the data phase that follows.
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ap_valid_q <= 1'b0;
            ap_write_q <= 1'b0;
            ap_addr_q <= 8'h00;
        end else begin
            ap_valid_q <= ap_take;
            ap_write_q <= hwrite_i;
            ap_addr_q <= haddr_i[7:0];
        end
    end

    // Read data and response. The slave never stalls and never errors, but
    // both stay registered so that every output comes from a flip-flop.
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hrdata_o <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            if (ap_take && !hwrite_i) begin
                hrdata_o <= rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Execution

    // Timing seen from the bus: the start write lands at the end of its data
    // phase and raises busy. A one-cycle operation or an untaken branch
    // retires at the next edge; a load, a store or a taken branch retires one
    // edge later. Writes that arrive while busy are dropped, so software
    // polls STATUS or waits out the two cycles before it writes again.

    // Memory address for the load/store forms, muxed once for the whole group.
    reg [15:0] maddr;
    always @* begin
        case (op)
            OP_LD_PTR, OP_LD_INC: maddr = ptr; // [RULE_15]
            OP_LD_DEC: maddr = ptr_dec; // [RULE_16]
            OP_LD_OFS: maddr = ptr + kval; // [RULE_17]
            OP_LD_ABS: maddr = kval; // [RULE_18]
            OP_ST_X, OP_ST_X_INC: maddr = xptr; // [RULE_19]
            default: maddr = ptr; // [RULE_15]
        endcase
    end

    // Data-phase write strobes, one per target. Writes are refused while an
    // instruction runs, so the operands cannot change under it.
    wire bus_wr = ap_valid_q & ap_write_q & ~busy_o;
    wire wr_instr = bus_wr & (ap_addr_q == `BRLD_OFS_INSTR);
    wire wr_opnd = bus_wr & (ap_addr_q == `BRLD_OFS_OPND);
    wire wr_flags = bus_wr & (ap_addr_q == `BRLD_OFS_FLAGS);
    wire wr_pc = bus_wr & (ap_addr_q == `BRLD_OFS_PC);
    wire wr_gpr = bus_wr & (ap_addr_q[7:6] == 2'b01);
    wire wr_mem = bus_wr & ap_addr_q[7];
    wire [4:0] wr_gpr_idx = {1'b0, ap_addr_q[5:2]};
    wire [5:0] wr_mem_idx = {ap_addr_q[6], ap_addr_q[6:2]};

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer, register file and memory update

    integer i;
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (i = 0; i < 32; i = i + 1) begin
                gpr_q[i] <= 8'h00;
            end
            for (i = 0; i < 64; i = i + 1) begin
                mem_q[i] <= 8'h00;
            end
            flags_q <= `BRLD_RST_FLAGS;
            instr_q <= 32'h0000_0000;
            opnd_q <= 32'h0000_0000;
            pc_o <= `BRLD_RST_PC;
            state_q <= ST_IDLE;
            cycles_q <= 2'd0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            if (wr_instr) instr_q <= hwdata_i;
            if (wr_opnd) opnd_q <= hwdata_i;
            if (wr_flags) flags_q <= hwdata_i[7:0];
            if (wr_pc) pc_o <= hwdata_i[15:0];
            if (wr_gpr) gpr_q[wr_gpr_idx] <= hwdata_i[7:0];
            if (wr_mem) mem_q[wr_mem_idx] <= hwdata_i[7:0];
            case (state_q)
                ST_IDLE: begin
                    // A start write while idle launches the staged instruction.
                    if (go_wr) begin
                        busy_o <= 1'b1;
                        done_o <= 1'b0;
                        state_q <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    case (op)
                        OP_BR_SET, OP_BR_CLR: begin
                            if (br_taken) begin
                                cycles_q <= `BRLD_CYC_TWO; // [RULE_20]
                                state_q <= ST_LAST;
                            end else begin
                                pc_o <= pc_o + 16'h0001; // [RULE_20]
                                cycles_q <= `BRLD_CYC_ONE;
                                busy_o <= 1'b0;
                                done_o <= 1'b1;
                                state_q <= ST_IDLE;
                            end
                        end
                        OP_COPY: begin
                            gpr_q[rd] <= gpr_q[rr]; // [RULE_14]
                            pc_o <= pc_o + 16'h0001;
                            cycles_q <= `BRLD_CYC_ONE;
                            busy_o <= 1'b0;
                            done_o <= 1'b1;
                            state_q <= ST_IDLE;
                        end
                        OP_COPY_PAIR: begin
                            gpr_q[{rd[4:1], 1'b0}] <= gpr_q[{rr[4:1], 1'b0}]; // [RULE_14]
                            gpr_q[{rd[4:1], 1'b1}] <= gpr_q[{rr[4:1], 1'b1}];
                            pc_o <= pc_o + 16'h0001;
                            cycles_q <= `BRLD_CYC_ONE;
                            busy_o <= 1'b0;
                            done_o <= 1'b1;
                            state_q <= ST_IDLE;
                        end
                        OP_LOAD_K: begin
                            gpr_q[rd] <= kval[7:0]; // [RULE_14]
                            pc_o <= pc_o + 16'h0001;
                            cycles_q <= `BRLD_CYC_ONE;
                            busy_o <= 1'b0;
                            done_o <= 1'b1;
                            state_q <= ST_IDLE;
                        end
                        OP_LD_PTR, OP_LD_INC, OP_LD_DEC, OP_LD_OFS, OP_LD_ABS: begin
                            // Pointer update and data move share the first cycle. If the
                            // destination is a pointer byte, the loaded byte wins.
                            if (is_ld_inc) begin
                                {gpr_q[pbase_hi], gpr_q[pbase]} <= ptr_inc; // [RULE_15]
                            end
                            if (is_ld_dec) begin
                                {gpr_q[pbase_hi], gpr_q[pbase]} <= ptr_dec; // [RULE_16]
                            end
                            gpr_q[rd] <= mem_q[maddr[5:0]]; // [RULE_15] [RULE_18]
                            cycles_q <= `BRLD_CYC_TWO;
                            state_q <= ST_LAST;
                        end
                        OP_ST_X, OP_ST_X_INC: begin
                            mem_q[maddr[5:0]] <= gpr_q[rr]; // [RULE_19]
                            if (is_st_x_inc) begin
                                {gpr_q[`BRLD_PTR_X + 5'd1], gpr_q[`BRLD_PTR_X]} <= xptr_inc; // [RULE_19]
                            end
                            cycles_q <= `BRLD_CYC_TWO;
                            state_q <= ST_LAST;
                        end
                        default: begin
                            // Unknown codes retire as two-cycle no-ops.
                            cycles_q <= `BRLD_CYC_TWO;
                            state_q <= ST_LAST;
                        end
                    endcase
                end
                ST_LAST: begin
                    // Second cycle: taken branch target, or finish of a
                    // two-cycle memory access.
                    if (is_branch) begin
                        pc_o <= br_target; // [RULE_01] [RULE_02] [RULE_21]
                    end else begin
                        pc_o <= pc_o + 16'h0001;
                    end
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

endmodule // brld_core

// file: verif/brld_core_asserts.sv
`timescale 1ns/1ps
module brld_core_asserts (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_b_i,
    // Bus
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire hready_i,
    input wire hreadyout_o,
    input wire hresp_o,
    // Execution status
    input wire busy_o,
    input wire done_o,
    input wire [15:0] pc_o
);
    // High in the data phase of a write to the start register.
    reg go_dp_q;
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            go_dp_q <= 1'b0;
        else if (hready_i)
            go_dp_q <= hsel_i & htrans_i[1] & hwrite_i & (haddr_i[7:0] == 8'h08);
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_finish;
        !busy_o && done_o;
    endsequence
    sequence s_short_run;
        $fell(busy_o) ##0 !$past(busy_o, 2);
    endsequence
    a_ready_high: assert property (hreadyout_o) else $error("hreadyout low");
    a_resp_okay: assert property (!hresp_o) else $error("hresp not okay");
    a_busy_bound: assert property ($rose(busy_o) |-> ##[1:2] s_finish)
        else $error("execution longer than two cycles");
    a_done_excl: assert property (!(busy_o && done_o)) else $error("busy and done together");
    a_fall_done: assert property ($fell(busy_o) |-> done_o) else $error("done missing");
    a_pc_change: assert property ($changed(pc_o) |-> $fell(busy_o))
        else $error("pc moved outside completion");
    a_pc_step: assert property (s_short_run |-> pc_o == $past(pc_o) + 16'h0001)
        else $error("one cycle run did not step pc by one");
    a_busy_cause: assert property ($rose(busy_o) |-> $past(go_dp_q))
        else $error("busy without start write");
    a_go_start: assert property (go_dp_q && hready_i && !busy_o |=> busy_o)
        else $error("start write ignored");
endmodule // brld_core_asserts

// file: verif/brld_core_tb_top.sv
`timescale 1ns/1ps
module brld_core_tb_top;
    logic sys_clk_i, rst_b_i, hsel_i, hwrite_i;
    logic [31:0] haddr_i, hwdata_i;
    logic [1:0] htrans_i;
    logic [2:0] hsize_i;
    wire [31:0] hrdata_o;
    wire hreadyout_o, hresp_o, busy_o, done_o;
    wire [15:0] pc_o;
    int bad_count = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [15:0] exp_pc = 16'h0000;
    brld_core u_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .busy_o(busy_o), .done_o(done_o),
        .pc_o(pc_o));
    ////////////////////////////////////////////////////////////////////////////////
    task end_of_test;
        $display("checks %0d bad %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge sys_clk_i);
        hsel_i <= 1'b1;
        haddr_i <= {24'h0, a};
        hwrite_i <= w;
        htrans_i <= 2'h2;
        do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
        r = hrdata_o;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(x, e);
    endtask
    // Counts the cycles in which busy stands until done is seen.
    task exec(input logic [4:0] op, rd, rr, input logic [2:0] fi, input logic [1:0] pt,
              input logic [15:0] v, output int n);
        wr(8'h00, {12'h0, pt, fi, rr, rd, op});
        wr(8'h04, {16'h0, v});
        wr(8'h08, 32'h1);
        n = 0;
        do begin
            @(posedge sys_clk_i);
            if (busy_o === 1'b1)
                n++;
        end while (done_o !== 1'b1);
    endtask
    task run(input logic [4:0] op, rd, rr, input logic [1:0] pt, input logic [15:0] v,
             input int en);
        int n;
        exec(op, rd, rr, 3'h0, pt, v, n);
        exp_pc = exp_pc + 16'h0001;
        chk(32'(n), 32'(en));
        chk({16'h0, pc_o}, {16'h0, exp_pc});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Pattern 8'h45 has S differing from N xor V, so a plain bit test shows up.
    task t_branch;
        logic [7:0] pat [3] = '{8'h45, 8'hBA, 8'h1C};
        logic [15:0] off;
        logic tk;
        int n;
        for (int p = 0; p < 3; p++) for (int i = 0; i < 8; i++) for (int o = 0; o < 2; o++) begin
            wr(8'h10, {24'h0, pat[p]});
            off = (o == 1) ? 16'hFFFD : 16'h0005;
            tk = ((i == 4) ? pat[p][2] ^ pat[p][3] : pat[p][i]) ^ o[0];
            exec(5'(o), 5'h0, 5'h0, 3'(i), 2'h0, off, n);
            exp_pc = tk ? exp_pc + off + 16'h0001 : exp_pc + 16'h0001;
            chk(32'(n), tk ? 32'h2 : 32'h1);
            chk({16'h0, pc_o}, {16'h0, exp_pc});
            rdchk(8'h10, {24'h0, pat[p]});
        end
    endtask
    task t_move;
        wr(8'h54, 32'hA7);
        wr(8'h58, 32'h5E);
        wr(8'h5C, 32'h61);
        run(5'd2, 5'd3, 5'd5, 2'h0, 16'h0, 1);
        rdchk(8'h4C, 32'hA7);
        run(5'd3, 5'd8, 5'd6, 2'h0, 16'h0, 1);
        rdchk(8'h60, 32'h5E);
        rdchk(8'h64, 32'h61);
    endtask
    // High registers overlap the memory window on the bus, so pointers are set by
    // constant loads and read back through copies into low registers.
    task t_mem;
        run(5'd4, 5'd26, 5'd0, 2'h0, 16'h10, 1);
        run(5'd4, 5'd27, 5'd0, 2'h0, 16'h0, 1);
        run(5'd11, 5'd0, 5'd5, 2'h0, 16'h0, 2);
        run(5'd10, 5'd0, 5'd6, 2'h0, 16'h0, 2);
        run(5'd2, 5'd11, 5'd26, 2'h0, 16'h0, 1);
        rdchk(8'h6C, 32'h11);
        run(5'd4, 5'd28, 5'd0, 2'h0, 16'h10, 1);
        run(5'd4, 5'd29, 5'd0, 2'h0, 16'h0, 1);
        run(5'd5, 5'd1, 5'd0, 2'h1, 16'h0, 2);
        rdchk(8'h44, 32'hA7);
        run(5'd6, 5'd2, 5'd0, 2'h1, 16'h0, 2);
        run(5'd2, 5'd12, 5'd28, 2'h0, 16'h0, 1);
        rdchk(8'h48, 32'hA7);
        rdchk(8'h70, 32'h11);
        run(5'd4, 5'd30, 5'd0, 2'h0, 16'h12, 1);
        run(5'd4, 5'd31, 5'd0, 2'h0, 16'h0, 1);
        run(5'd7, 5'd4, 5'd0, 2'h2, 16'h0, 2);
        run(5'd2, 5'd13, 5'd30, 2'h0, 16'h0, 1);
        rdchk(8'h50, 32'h5E);
        rdchk(8'h74, 32'h11);
        run(5'd4, 5'd30, 5'd0, 2'h0, 16'h0F, 1);
        run(5'd8, 5'd9, 5'd0, 2'h2, 16'h1, 2);
        run(5'd2, 5'd13, 5'd30, 2'h0, 16'h0, 1);
        rdchk(8'h64, 32'hA7);
        rdchk(8'h74, 32'h0F);
        run(5'd9, 5'd7, 5'd0, 2'h0, 16'h11, 2);
        rdchk(8'h5C, 32'h5E);
        rdchk(8'h10, 32'h1C);
        rdchk(8'h0C, 32'h0000_000A);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        rst_b_i = 1'b0;
        hsel_i = 1'b0;
        hwrite_i = 1'b0;
        haddr_i = 32'h0;
        hwdata_i = 32'h0;
        htrans_i = 2'h0;
        hsize_i = 3'h2;
        repeat (3) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        t_branch();
        t_move();
        t_mem();
        end_of_test();
    end
endmodule // brld_core_tb_top
bind brld_core brld_core_asserts u_chk (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .busy_o(busy_o),
    .done_o(done_o), .pc_o(pc_o));
